// ---- port_group_zero_register_bank.sv ----
// Register bank, pin control and interrupt logic of the first port group
//
// Operation
// - Every pin offers general-purpose input/output plus an input-driven interrupt.
// - Control bits of pins the variant lacks are reserved and drive nothing.
// - Pin interrupt flags clear only on writing one; zero leaves them; reset zero.
// - Data register: output latches in 15:8, read-only pin inputs in 7:0.
// - Enable register: input enables in 15:8, output enables in 7:0.
// - Pull register: pull direction in 15:8, pull resistor enables in 7:0.
// - Interrupt control: edge selects in 15:8, interrupt enables in 7:0.
// - Filter enables in 7:0, upper byte reads zero.
// - Filter enable one routes the input through the filter, zero bypasses it.
// - Group summary clears by itself once the causing pin flags are cleared.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module port_group_zero_register_bank
    import port_group_pkg::*;
#(
    parameter int unsigned NUM_PINS       = PIN_COUNT,
    parameter logic [7:0]  PIN_AVAIL_MASK = 8'hff,
    parameter int unsigned FILTER_CYCLES  = DEBOUNCE_CYCLES
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic [7:0]  pin_in_i,
    output logic      [7:0]  pin_out_o,
    output logic      [7:0]  pin_oe_o,
    output logic      [7:0]  pin_pull_en_o,
    output logic      [7:0]  pin_pull_up_o,
    // Group interrupt request, level
    output logic             irq_o
);

    generate
        if (NUM_PINS != 8) begin : g_bad_pins
            $error("Register layout serves exactly eight pins");
        end
        if (FILTER_CYCLES < 1) begin : g_bad_filter
            $error("FILTER_CYCLES must be at least one");
        end
    endgenerate

    // Mask writes to absent pins so their bits stay at the reset value
    function automatic logic [7:0] avail(input logic [7:0] v);
        return v & PIN_AVAIL_MASK;
    endfunction

    // Merge one byte of a write under its byte strobe
    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v, input logic en);
        return en ? new_v : old_v;
    endfunction

    // Word decode shared by the write and read paths; the low two address bits are ignored
    function automatic logic hits(input logic [5:0] word, input logic [7:0] ofs);
        return word == ofs[7:2];
    endfunction

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] out_latch_q;
    logic [7:0] in_en_q;
    logic [7:0] out_en_q;
    logic [7:0] pull_dir_q;
    logic [7:0] pull_en_q;
    logic [7:0] edge_sel_q;
    logic [7:0] int_en_q;
    logic [7:0] debounce_en_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] in_prev_q;

    // ------------------------------------------------------------------
    // Write channel: address and data are held until both have arrived
    // ------------------------------------------------------------------
    logic       aw_have_q;
    logic       w_have_q;
    logic [7:0] aw_addr_q;
    logic [15:0] w_data_q;
    logic [1:0] w_strb_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;

    wire logic aw_fire  = s_axi_awvalid && s_axi_awready;
    wire logic w_fire   = s_axi_wvalid && s_axi_wready;
    // The write lands once both halves are held, and new halves wait until it is answered
    wire logic wr_do    = aw_have_q && w_have_q && !bvalid_q;
    wire logic b_fire   = s_axi_bvalid && s_axi_bready;

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    wire logic [5:0] wr_word = aw_addr_q[7:2];
    wire logic wr_data_sel  = wr_do && hits(wr_word, PORT_DATA_OFS);
    wire logic wr_ioen_sel  = wr_do && hits(wr_word, PORT_IO_ENABLE_OFS);
    wire logic wr_pull_sel  = wr_do && hits(wr_word, PULL_CONTROL_OFS);
    wire logic wr_flag_sel  = wr_do && hits(wr_word, INTERRUPT_FLAGS_OFS);
    wire logic wr_ictl_sel  = wr_do && hits(wr_word, INTERRUPT_CTRL_OFS);
    wire logic wr_deb_sel   = wr_do && hits(wr_word, DEBOUNCE_ENABLE_OFS);
    wire logic wr_sum_sel   = wr_do && hits(wr_word, GROUP_SUMMARY_OFS);
    wire logic wr_mapped    = wr_data_sel || wr_ioen_sel || wr_pull_sel || wr_flag_sel
                            || wr_ictl_sel || wr_deb_sel || wr_sum_sel;

    wire logic [7:0] wr_hi  = w_data_q[15:8];
    wire logic [7:0] wr_lo  = w_data_q[7:0];
    wire logic       en_hi  = w_strb_q[1];
    wire logic       en_lo  = w_strb_q[0];

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (aw_fire) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w_have_q <= 1'b0;
            w_data_q <= 16'h0000;
            w_strb_q <= 2'h0;
        end else if (w_fire) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb[1:0];
        end else if (wr_do) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bvalid_q <= 1'b0;
        end else if (wr_do) begin
            bvalid_q <= 1'b1;
        end else if (b_fire) begin
            bvalid_q <= 1'b0;
        end
    end

    // The code is captured with the write so it stands until the answer is taken
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bresp_q <= RESP_OKAY;
        end else if (wr_do) begin
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // Control registers; absent pins never take a written one
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_latch_q <= PORT_DATA_RST;
        end else if (wr_data_sel) begin
            out_latch_q <= avail(merge(out_latch_q, wr_hi, en_hi));
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_en_q  <= PORT_IO_ENABLE_RST;
            out_en_q <= PORT_IO_ENABLE_RST;
        end else if (wr_ioen_sel) begin
            in_en_q  <= avail(merge(in_en_q, wr_hi, en_hi));
            out_en_q <= avail(merge(out_en_q, wr_lo, en_lo));
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pull_dir_q <= PULL_CONTROL_RST;
            pull_en_q  <= PULL_CONTROL_RST;
        end else if (wr_pull_sel) begin
            pull_dir_q <= avail(merge(pull_dir_q, wr_hi, en_hi));
            pull_en_q  <= avail(merge(pull_en_q, wr_lo, en_lo));
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            edge_sel_q <= INTERRUPT_CTRL_RST;
            int_en_q   <= INTERRUPT_CTRL_RST;
        end else if (wr_ictl_sel) begin
            edge_sel_q <= avail(merge(edge_sel_q, wr_hi, en_hi));
            int_en_q   <= avail(merge(int_en_q, wr_lo, en_lo));
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            debounce_en_q <= DEBOUNCE_ENABLE_RST;
        end else if (wr_deb_sel) begin
            debounce_en_q <= avail(merge(debounce_en_q, wr_lo, en_lo));
        end
    end

    // ------------------------------------------------------------------
    // Input path: filter, input enable gate, edge detection
    // ------------------------------------------------------------------
    logic [7:0] in_clean;

    port_debounce_filter #(
        .WIDTH         (NUM_PINS),
        .STABLE_CYCLES (FILTER_CYCLES)
    ) u_filter (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .raw_i       (pin_in_i),
        .filter_en_i (debounce_en_q),
        .clean_o     (in_clean)
    );

    // A disabled input reads low, so disabling a high input counts as a falling edge
    wire logic [7:0] in_value = in_clean & in_en_q;

    // Resets low like a disabled input, so no false edge follows reset
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_prev_q <= 8'h00;
        end else begin
            in_prev_q <= in_value;
        end
    end

    // Edge select zero picks the rising edge, one the falling edge
    wire logic [7:0] rise_seen  = in_value & ~in_prev_q;
    wire logic [7:0] fall_seen  = ~in_value & in_prev_q;
    wire logic [7:0] edge_hit   = (edge_sel_q & fall_seen) | (~edge_sel_q & rise_seen);
    wire logic [7:0] flag_set   = avail(edge_hit);
    wire logic [7:0] flag_clr   = (wr_flag_sel && en_lo) ? wr_lo : 8'h00;

    // A new edge in the clearing cycle survives the clear
    assign flags_d = (flags_q & ~flag_clr) | flag_set;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_q <= INTERRUPT_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Summary is derived, not stored, so it drops as soon as the flags do
    wire logic group_summary = |(flags_q & int_en_q);
    assign irq_o = group_summary;

    // ------------------------------------------------------------------
    // Pin drive; outputs are flops or flop-gated, absent pins stay quiet
    // ------------------------------------------------------------------
    assign pin_out_o     = out_latch_q & out_en_q;
    assign pin_oe_o      = out_en_q;
    // A driven pin never also pulls, so the resistor cannot fight the driver
    assign pin_pull_en_o = pull_en_q & ~out_en_q;
    // Direction one pulls up, zero pulls down
    assign pin_pull_up_o = pull_dir_q;

    // ------------------------------------------------------------------
    // Read channel: one read in flight, answered the cycle after acceptance
    // ------------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire logic ar_fire = s_axi_arvalid && s_axi_arready;
    wire logic r_fire  = s_axi_rvalid && s_axi_rready;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    wire logic [5:0] rd_word = s_axi_araddr[7:2];
    wire logic rd_data_sel  = hits(rd_word, PORT_DATA_OFS);
    wire logic rd_ioen_sel  = hits(rd_word, PORT_IO_ENABLE_OFS);
    wire logic rd_pull_sel  = hits(rd_word, PULL_CONTROL_OFS);
    wire logic rd_flag_sel  = hits(rd_word, INTERRUPT_FLAGS_OFS);
    wire logic rd_ictl_sel  = hits(rd_word, INTERRUPT_CTRL_OFS);
    wire logic rd_deb_sel   = hits(rd_word, DEBOUNCE_ENABLE_OFS);
    wire logic rd_sum_sel   = hits(rd_word, GROUP_SUMMARY_OFS);
    wire logic rd_mapped    = rd_data_sel || rd_ioen_sel || rd_pull_sel || rd_flag_sel
                            || rd_ictl_sel || rd_deb_sel || rd_sum_sel;

    wire logic [15:0] summary_word = 16'(group_summary) << SUMMARY_BIT;
    wire logic [15:0] rd_word_val =
          rd_data_sel ? {out_latch_q, in_value}
        : rd_ioen_sel ? {in_en_q, out_en_q}
        : rd_pull_sel ? {pull_dir_q, pull_en_q}
        : rd_flag_sel ? {8'h00, flags_q}
        : rd_ictl_sel ? {edge_sel_q, int_en_q}
        : rd_deb_sel  ? {8'h00, debounce_en_q}
        : rd_sum_sel  ? summary_word
        : 16'h0000;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rvalid_q <= 1'b0;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
        end else if (r_fire) begin
            rvalid_q <= 1'b0;
        end
    end

    // Data is captured at acceptance so it stands unchanged until the master takes it
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ar_fire) begin
            rdata_q <= {16'h0000, rd_word_val};
            rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

endmodule

// ---- port_group_pkg.sv ----
// Constants shared by the port group register bank and its input filter
package port_group_pkg;

    localparam int unsigned PIN_COUNT       = 8;
    localparam int unsigned REG_ADDR_W      = 8;
    localparam int unsigned REG_DATA_W      = 16;

    // Byte addresses of the registers on the bus
    localparam logic [7:0] PORT_DATA_OFS        = 8'h00;
    localparam logic [7:0] PORT_IO_ENABLE_OFS   = 8'h04;
    localparam logic [7:0] PULL_CONTROL_OFS     = 8'h08;
    localparam logic [7:0] INTERRUPT_FLAGS_OFS  = 8'h0c;
    localparam logic [7:0] INTERRUPT_CTRL_OFS   = 8'h10;
    localparam logic [7:0] DEBOUNCE_ENABLE_OFS  = 8'h14;
    localparam logic [7:0] GROUP_SUMMARY_OFS    = 8'h18;

    // Field positions: upper byte and lower byte of each 16-bit register
    localparam int unsigned HI_FIELD_LSB    = 8;
    localparam int unsigned LO_FIELD_LSB    = 0;
    localparam int unsigned SUMMARY_BIT     = 0;

    // Values after reset
    localparam logic [7:0] PORT_DATA_RST        = 8'h00;
    localparam logic [7:0] PORT_IO_ENABLE_RST   = 8'h00;
    localparam logic [7:0] PULL_CONTROL_RST     = 8'h00;
    localparam logic [7:0] INTERRUPT_FLAGS_RST  = 8'h00;
    localparam logic [7:0] INTERRUPT_CTRL_RST   = 8'h00;
    localparam logic [7:0] DEBOUNCE_ENABLE_RST  = 8'h00;

    // Debounce: input must stay stable this long before it is passed on
    localparam int unsigned CLK_FREQ_HZ         = 25_000_000;
    localparam int unsigned DEBOUNCE_TIME_NS    = 640;
    localparam int unsigned DEBOUNCE_CYCLES     =
        (DEBOUNCE_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

    // AXI4-Lite response codes
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage

// ---- port_debounce_filter.sv ----
// Per-pin chattering filter with bypass
`timescale 1ns/1ns
module port_debounce_filter
    import port_group_pkg::*;
#(
    parameter int unsigned WIDTH         = PIN_COUNT,
    parameter int unsigned STABLE_CYCLES = DEBOUNCE_CYCLES
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] raw_i,
    input  wire logic [WIDTH-1:0] filter_en_i,
    output logic      [WIDTH-1:0] clean_o
);
    localparam int unsigned CNT_W = $clog2(STABLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

    generate
        if (STABLE_CYCLES < 1) begin : g_bad_count
            $error("STABLE_CYCLES must be at least one");
        end
    endgenerate

    logic [WIDTH-1:0] stable_q;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            logic [CNT_W-1:0] cnt_q;
            logic [CNT_W-1:0] cnt_d;
            logic             stable_d;
            wire logic        differs = raw_i[gi] != stable_q[gi];
            wire logic        expired = differs && (cnt_q == CNT_LAST);

            // Bypassed pins track the raw level so enabling the filter causes no glitch
            assign stable_d = (!filter_en_i[gi] || expired) ? raw_i[gi] : stable_q[gi];
            assign cnt_d    = (!filter_en_i[gi] || !differs || expired) ? '0 : cnt_q + 1'b1;

            always_ff @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cnt_q        <= '0;
                    stable_q[gi] <= 1'b0;
                end else begin
                    cnt_q        <= cnt_d;
                    stable_q[gi] <= stable_d;
                end
            end
            // Bypass is combinational so an unfiltered pin costs no latency
            assign clean_o[gi] = filter_en_i[gi] ? stable_q[gi] : raw_i[gi];
        end
    endgenerate
endmodule

// ---- port_group_properties.sv ----
// Concurrent checks on the ports of the port group register bank
`timescale 1ns/1ns
module port_group_properties #(
    parameter logic [7:0] PIN_AVAIL_MASK = 8'hff
) (
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  pin_out_o,
    input wire logic [7:0]  pin_oe_o,
    input wire logic [7:0]  pin_pull_en_o,
    input wire logic        irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // A register changes only at the edge that also raises the write answer
    sequence wr_commit;
        $rose(s_axi_bvalid);
    endsequence
    a_out_needs_oe: assert property ((pin_out_o & ~pin_oe_o) == 8'h00)
        else $error("pin output high while not driven");
    a_pull_not_driven: assert property ((pin_pull_en_o & pin_oe_o) == 8'h00)
        else $error("pull enabled on a driven pin");
    a_absent_pins_idle: assert property (((pin_oe_o | pin_pull_en_o) & ~PIN_AVAIL_MASK) == 8'h00)
        else $error("absent pin is active");
    a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_irq_falls_write: assert property ($fell(irq_o) |-> wr_commit)
        else $error("interrupt dropped without a write");
    a_oe_by_write: assert property ($changed(pin_oe_o) |-> wr_commit)
        else $error("output enable changed without a write");
    a_write_answer: assert property (aw_w_taken |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
endmodule

// ---- pin_world.sv ----
// Outside world of the pads: bank drive, pull resistors and an outside driver
`timescale 1ns/1ns
module pin_world (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [7:0] pin_pull_en_i,
    input  wire logic [7:0] pin_pull_up_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] pin_level_o
);
    logic [7:0] last_q;
    always_ff @(posedge core_clk_i) last_q <= pin_level_o;
    // An undriven pad flips so a stale level can never pass for a real one
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_i[i]) pin_level_o[i] = pin_out_i[i];
            else if (ext_en_i[i]) pin_level_o[i] = ext_val_i[i];
            else if (pin_pull_en_i[i]) pin_level_o[i] = pin_pull_up_i[i];
            else pin_level_o[i] = ~last_q[i];
        end
    end
endmodule

// ---- tb_port_group_zero_register_bank.sv ----
// Self-checking bench for the port group register bank
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb_port_group_zero_register_bank;
    import port_group_pkg::*;
    localparam logic [7:0] AVAIL = 8'h0f;
    logic        core_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ext_en = 8'hff, ext_val = 8'h00;
    logic [7:0]  pin_in, pin_out, pin_oe, pull_en, pull_up;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'h3;
    logic [1:0]  bresp, rresp;
    int          fails = 0, checks_done = 0, cycles = 0;

    always #20 core_clk_i = ~core_clk_i;

    port_group_zero_register_bank #(.PIN_AVAIL_MASK(AVAIL), .FILTER_CYCLES(2)) i_port_group_zero_register_bank (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .pin_pull_en_o(pull_en), .pin_pull_up_o(pull_up), .irq_o(irq));

    pin_world i_pin_world (.core_clk_i(core_clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .pin_pull_en_i(pull_en), .pin_pull_up_i(pull_up), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_level_o(pin_in));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            close_out();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge core_clk_i);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk_i);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk_i); while (!bvalid);
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] er = RESP_OKAY);
        @(posedge core_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk_i); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk_i); while (!rvalid);
        `CHK("rdata", {16'h0000, exp}, rdata)
        `CHK("rresp", er, rresp)
        rready <= 1'b0;
    endtask

    task automatic t_reset_values();
        for (int a = 0; a <= 24; a += 4) rd(8'(a), 16'h0000);
    endtask

    // Writes to absent pins must be dropped, so patterns cover both nibbles
    task automatic t_regs();
        logic [7:0] ofs [4] = '{8'h04, 8'h08, 8'h10, 8'h14};
        for (int i = 0; i < 4; i++) wr(ofs[i], 16'ha55a);
        for (int i = 0; i < 3; i++) rd(ofs[i], {8'ha5 & AVAIL, 8'h5a & AVAIL});
        rd(8'h14, {8'h00, 8'h5a & AVAIL});
        `CHK("pin_oe", 8'h5a & AVAIL, pin_oe)
        `CHK("pull_up", 8'ha5 & AVAIL, pull_up)
        `CHK("pull_en", 8'h00, pull_en)
        wstrb <= 4'h2;
        wr(8'h08, 16'h0000);
        rd(8'h08, {8'h00, 8'h5a & AVAIL});
        wstrb <= 4'h3;
        for (int i = 0; i < 4; i++) wr(ofs[i], 16'h0000);
    endtask

    task automatic t_data();
        ext_en <= 8'hf0;
        wr(8'h04, 16'h0f0f);
        wr(8'h08, 16'h000f);
        wr(8'h00, 16'h05ff);
        `CHK("pin_out", 8'h05, pin_out)
        `CHK("pull_en", 8'h00, pull_en)
        rd(8'h00, 16'h0505);
        ext_en <= 8'hff;
        wr(8'h04, 16'h0f00);
        `CHK("pin_out", 8'h00, pin_out)
        `CHK("pull_en", 8'h0f, pull_en)
        wr(8'h08, 16'h0000);
    endtask

    task automatic t_irq();
        wr(8'h0c, 16'h00ff);
        wr(8'h10, 16'h0203);
        ext_val <= 8'h01;
        repeat (3) @(posedge core_clk_i);
        `CHK("irq", 1'b1, irq)
        rd(8'h0c, 16'h0001);
        rd(8'h18, 16'h0001);
        ext_val <= 8'h03;
        wr(8'h0c, 16'h0000);
        rd(8'h0c, 16'h0001);
        ext_val <= 8'h01;
        repeat (3) @(posedge core_clk_i);
        rd(8'h0c, 16'h0003);
        wr(8'h0c, 16'h0001);
        rd(8'h0c, 16'h0002);
        `CHK("irq", 1'b1, irq)
        wr(8'h0c, 16'h0002);
        rd(8'h0c, 16'h0000);
        `CHK("irq", 1'b0, irq)
        rd(8'h18, 16'h0000);
        ext_val <= 8'h05;
        repeat (3) @(posedge core_clk_i);
        rd(8'h0c, 16'h0004);
        `CHK("irq", 1'b0, irq)
        wr(8'h0c, 16'h0004);
        wr(8'h10, 16'h0000);
    endtask

    task automatic t_filter();
        ext_val <= 8'h00;
        wr(8'h14, 16'h0001);
        repeat (4) @(posedge core_clk_i);
        ext_val <= 8'h01;
        @(posedge core_clk_i);
        ext_val <= 8'h00;
        repeat (4) @(posedge core_clk_i);
        rd(8'h00, 16'h0500);
        rd(8'h0c, 16'h0000);
        ext_val <= 8'h01;
        repeat (6) @(posedge core_clk_i);
        rd(8'h00, 16'h0501);
    endtask

    task automatic t_bad_addr();
        wr(8'h20, 16'hffff, RESP_SLVERR);
        rd(8'h1c, 16'h0000, RESP_SLVERR);
        wr(8'h18, 16'hffff);
        rd(8'h18, 16'h0000);
    endtask

    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        t_reset_values();
        t_regs();
        t_data();
        t_irq();
        t_filter();
        t_bad_addr();
        close_out();
    end
endmodule

bind port_group_zero_register_bank port_group_properties #(.PIN_AVAIL_MASK(PIN_AVAIL_MASK)) i_port_group_properties (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .pin_pull_en_o(pin_pull_en_o), .irq_o(irq_o));
